// >>> logic/ptd_defs.svh
// Field positions, widths and register offsets of the page-table-pointer decoder
`ifndef PTD_DEFS_SVH
`define PTD_DEFS_SVH
`define PTD_HAW            6'h30
`define PTD_BIT_NOEXEC     63
`define PTD_BIT_EXT_USE    10
`define PTD_BIT_LARGE      7
`define PTD_BIT_ACCESSED   5
`define PTD_BIT_CACHE_DIS  4
`define PTD_BIT_WR_THRU    3
`define PTD_BIT_USER       2
`define PTD_BIT_WRITE      1
`define PTD_BIT_PRESENT    0
`define PTD_ADDR_LSB       12
`define PTD_RSVD_MSB       51
`define PTD_TT_NESTED      3'h3
`define PTD_CTRL_NOEXEC    0
`define PTD_CTRL_EXT_USE   1
`define PTD_CTRL_SUP_WP    2
`define PTD_CTRL_TT_LSB    3
`define PTD_CTRL_TT_MSB    5
`define PTD_CTRL_COHERENT  6
`define PTD_REQ_USER       0
`define PTD_REQ_WRITE      1
`define PTD_REQ_EXEC       2
`define PTD_REQ_START      3
`define PTD_ST_DONE        0
`define PTD_ST_TABLE       1
`define PTD_ST_FAULT       2
`define PTD_ST_DENY        3
`define PTD_ST_NESTED      4
`define PTD_OFF_ENTRY_LO   12'h000
`define PTD_OFF_ENTRY_HI   12'h004
`define PTD_OFF_CTRL       12'h008
`define PTD_OFF_REQ        12'h00C
`define PTD_OFF_STATUS     12'h010
`define PTD_OFF_TABLE_LO   12'h014
`define PTD_OFF_TABLE_HI   12'h018
`define PTD_OFF_WB_LO      12'h01C
`define PTD_OFF_WB_HI      12'h020
`endif

// >>> logic/ptd_pkg.sv
// Types shared by the page-table-pointer decoder
package ptd_pkg;
    typedef enum logic [1:0] {PTD_IDLE, PTD_DECODE, PTD_DONE} ptd_state_e;
    typedef logic [63:0] ptd_entry_t;
endpackage

// >>> logic/ptd_entry_check.sv
// Combinational decode and permission check of one directory entry
`include "ptd_defs.svh"
module ptd_entry_check
    import ptd_pkg::*;
(
    input  wire ptd_entry_t  entry,
    input  wire logic        exec_protect_enable,
    input  wire logic        ext_use_track_enable,
    input  wire logic        supervisor_write_protect,
    input  wire logic [2:0]  translation_type_field,
    input  wire logic        coherent_req,
    input  wire logic        req_user,
    input  wire logic        req_write,
    input  wire logic        req_exec,
    output logic             is_table,
    output logic             rsvd_fault,
    output logic             deny,
    output logic             nested,
    output logic [1:0]       mem_hint,
    output logic             set_ext_use,
    output logic [63:0]      table_addr
);
    logic [63:0] rsvd_mask;

    // Reserved bits span 51 down to the host address width
    always_comb begin
        rsvd_mask = '0;
        for (int i = 0; i < 64; i++) begin
            if (i <= `PTD_RSVD_MSB && i >= int'(`PTD_HAW)) begin
                rsvd_mask[i] = 1'b1;
            end
        end
    end

    // Decode; bits 62:52, 11, 9:8 and 6 never enter any term
    always_comb begin
        is_table   = entry[`PTD_BIT_PRESENT] & ~entry[`PTD_BIT_LARGE];
        rsvd_fault = entry[`PTD_BIT_PRESENT] & |(entry & rsvd_mask);
        table_addr = '0;
        for (int i = `PTD_ADDR_LSB; i < 64; i++) begin
            if (i < int'(`PTD_HAW)) begin
                table_addr[i] = entry[i];
            end
        end
        nested     = (translation_type_field == `PTD_TT_NESTED);
        mem_hint   = coherent_req ? {entry[`PTD_BIT_CACHE_DIS], entry[`PTD_BIT_WR_THRU]} : 2'h0;
        set_ext_use = ext_use_track_enable;
        deny = (req_exec & exec_protect_enable & entry[`PTD_BIT_NOEXEC])
             | (req_user & ~entry[`PTD_BIT_USER])
             | (req_write & ~entry[`PTD_BIT_WRITE] & (req_user | supervisor_write_protect));
    end
endmodule

// >>> logic/ptd_decoder.sv
// APB-controlled decoder for a directory entry that points to a page table
// Behaviour
// - Deny execute in the region when exec protection enabled and bit 63 set.
// - Next table address is bits host_addr_width-1 down to 12.
// - Nested translation type marks the table address as guest physical.
// - Bit 10 records use only when extended tracking enabled, else ignored.
// - Entry points to a table only when bit 7 is 0.
// - Bit 5 is the accessed flag, set when the entry is used.
// - Bits 4 and 3 give memory-type hints only for coherent requesters.
// - Bit 2 clear refuses user-level requests to the region.
// - Bit 1 clear denies user writes, and supervisor writes under protection.
// - Entry is valid for referencing a table only when bit 0 is 1.
//
// ==========================================================
// Register map, one aligned 32-bit word each
// 0x00 entry word, bits 31:0, read and write
// 0x04 entry word, bits 63:32, read and write
// 0x08 control word, read and write
// 0x0C request word, read and write; bit 3 is a start strobe, not stored
// 0x10 status word, read only; a write is taken and ignored
// 0x14 next table address, bits 31:0, read only
// 0x18 next table address, bits 63:32, read only
// 0x1C written-back entry, bits 31:0, read only
// 0x20 written-back entry, bits 63:32, read only
// Other offsets, and writes to read-only results, answer with pslverr
//
// Control word
// [0] exec protection enable, [1] use tracking enable
// [2] supervisor write protection, [5:3] translation type, [6] coherent requester
//
// Request word
// [0] user level, [1] write, [2] execute, [3] start
//
// Status word
// [0] done, [1] table valid, [2] fault, [3] deny, [4] nested
// [7:6] cache-disable and write-through hints, zero for other requesters
//
// Sequence
// A start while idle decodes for one cycle, then posts status and results
// A start while a decode runs is dropped; poll the done bit instead
// Results stand until the next start; hints follow the live words
//
// Limitations
// Fault covers a clear present bit, a large mapping and reserved bits
// Deny is worked out whether or not the entry is valid
// Flags are written back only for a usable table pointer
//
// The implementer's own choices: the address map and the APB register port.
`include "ptd_defs.svh"
module ptd_decoder
    import ptd_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    // ==========================================================
    // Register state
    ptd_state_e  state;
    ptd_state_e  next_state;
    ptd_entry_t  entry;
    ptd_entry_t  next_entry;
    logic [6:0]  ctrl;
    logic [6:0]  next_ctrl;
    logic [2:0]  req;
    logic [2:0]  next_req;
    logic [5:0]  status;
    logic [5:0]  next_status;
    logic [63:0] table_q;
    logic [63:0] next_table_q;
    logic [63:0] wb;
    logic [63:0] next_wb;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;

    logic        is_table;
    logic        rsvd_fault;
    logic        deny;
    logic        nested;
    logic [1:0]  mem_hint;
    logic        set_ext_use;
    logic [63:0] table_addr;
    logic        wr_acc;
    logic        rd_acc;
    logic        start;
    logic        exec_protect_enable;
    logic        ext_use_track_enable;
    logic        supervisor_write_protect;
    logic [2:0]  translation_type_field;
    logic        coherent_req;
    logic        req_user;
    logic        req_write;
    logic        req_exec;

    // ==========================================================
    // Control and request fields
    always_comb begin
        exec_protect_enable      = ctrl[`PTD_CTRL_NOEXEC];
        ext_use_track_enable     = ctrl[`PTD_CTRL_EXT_USE];
        supervisor_write_protect = ctrl[`PTD_CTRL_SUP_WP];
        translation_type_field   = ctrl[`PTD_CTRL_TT_MSB:`PTD_CTRL_TT_LSB];
        coherent_req             = ctrl[`PTD_CTRL_COHERENT];
        req_user                 = req[`PTD_REQ_USER];
        req_write                = req[`PTD_REQ_WRITE];
        req_exec                 = req[`PTD_REQ_EXEC];
    end

    // Permission check and field decode of the held entry
    ptd_entry_check u_ptd_entry_check (
        .entry                    (entry),
        .exec_protect_enable      (exec_protect_enable),
        .ext_use_track_enable     (ext_use_track_enable),
        .supervisor_write_protect (supervisor_write_protect),
        .translation_type_field   (translation_type_field),
        .coherent_req             (coherent_req),
        .req_user                 (req_user),
        .req_write                (req_write),
        .req_exec                 (req_exec),
        .is_table                 (is_table),
        .rsvd_fault               (rsvd_fault),
        .deny                     (deny),
        .nested                   (nested),
        .mem_hint                 (mem_hint),
        .set_ext_use              (set_ext_use),
        .table_addr               (table_addr)
    );

    // ==========================================================
    // APB access strobes; one wait state per access
    always_comb begin
        wr_acc = psel & penable & ~pready & pwrite;
        rd_acc = psel & penable & ~pready & ~pwrite;
        start  = wr_acc & (paddr == `PTD_OFF_REQ) & pwdata[`PTD_REQ_START];
    end

    // ==========================================================
    // Decode sequence: start, one decode cycle, results posted
    always_comb begin
        next_state   = state;
        next_status  = status;
        next_table_q = table_q;
        next_wb      = wb;
        case (state)
            PTD_IDLE: begin
                if (start) begin
                    next_state  = PTD_DECODE;
                    next_status = 6'h00;
                end
            end
            PTD_DECODE: begin
                next_state   = PTD_DONE;
                next_table_q = table_addr;
                next_wb      = entry;
                next_status  = 6'h00;
                next_status[`PTD_ST_DONE]   = 1'b1;
                next_status[`PTD_ST_TABLE]  = is_table & ~rsvd_fault;
                next_status[`PTD_ST_FAULT]  = rsvd_fault | ~is_table;
                next_status[`PTD_ST_DENY]   = deny;
                next_status[`PTD_ST_NESTED] = nested;
                // Flags are written back only for a usable table pointer
                if (is_table & ~rsvd_fault) begin
                    next_wb[`PTD_BIT_ACCESSED] = 1'b1;
                    if (set_ext_use) begin
                        next_wb[`PTD_BIT_EXT_USE] = 1'b1;
                    end
                end
            end
            PTD_DONE: begin
                next_state = PTD_IDLE;
            end
            default: begin
                next_state = PTD_IDLE;
            end
        endcase
    end

    // Decode sequence registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= PTD_IDLE;
            status  <= 6'h00;
            table_q <= 64'h0;
            wb      <= 64'h0;
        end else begin
            state   <= next_state;
            status  <= next_status;
            table_q <= next_table_q;
            wb      <= next_wb;
        end
    end

    // ==========================================================
    // Register file: entry, control and request words
    always_comb begin
        next_entry = entry;
        next_ctrl  = ctrl;
        next_req   = req;
        if (wr_acc) begin
            if (paddr == `PTD_OFF_ENTRY_LO) begin
                next_entry[31:0] = pwdata;
            end else if (paddr == `PTD_OFF_ENTRY_HI) begin
                next_entry[63:32] = pwdata;
            end else if (paddr == `PTD_OFF_CTRL) begin
                next_ctrl = pwdata[6:0];
            end else if (paddr == `PTD_OFF_REQ) begin
                next_req = pwdata[2:0];
            end
        end
    end

    // Register file registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            entry <= 64'h0;
            ctrl  <= 7'h00;
            req   <= 3'h0;
        end else begin
            entry <= next_entry;
            ctrl  <= next_ctrl;
            req   <= next_req;
        end
    end

    // ==========================================================
    // Bus answer: one wait state, refusal of unmapped offsets
    always_comb begin
        next_prdata  = prdata;
        next_pready  = psel & penable & ~pready;
        next_pslverr = 1'b0;
        // Status takes a write and ignores it; results refuse writes
        if (wr_acc) begin
            if (paddr == `PTD_OFF_ENTRY_LO) begin
                next_pslverr = 1'b0;
            end else if (paddr == `PTD_OFF_ENTRY_HI) begin
                next_pslverr = 1'b0;
            end else if (paddr == `PTD_OFF_CTRL) begin
                next_pslverr = 1'b0;
            end else if (paddr == `PTD_OFF_REQ) begin
                next_pslverr = 1'b0;
            end else if (paddr == `PTD_OFF_STATUS) begin
                next_pslverr = 1'b0;
            end else begin
                next_pslverr = 1'b1;
            end
        end
        // Read data stands until the next read
        if (rd_acc) begin
            if (paddr == `PTD_OFF_ENTRY_LO) begin
                next_prdata = entry[31:0];
            end else if (paddr == `PTD_OFF_ENTRY_HI) begin
                next_prdata = entry[63:32];
            end else if (paddr == `PTD_OFF_CTRL) begin
                next_prdata = {25'h0, ctrl};
            end else if (paddr == `PTD_OFF_REQ) begin
                next_prdata = {29'h0, req};
            end else if (paddr == `PTD_OFF_STATUS) begin
                next_prdata = {24'h0, mem_hint, status};
            end else if (paddr == `PTD_OFF_TABLE_LO) begin
                next_prdata = table_q[31:0];
            end else if (paddr == `PTD_OFF_TABLE_HI) begin
                next_prdata = table_q[63:32];
            end else if (paddr == `PTD_OFF_WB_LO) begin
                next_prdata = wb[31:0];
            end else if (paddr == `PTD_OFF_WB_HI) begin
                next_prdata = wb[63:32];
            end else begin
                next_prdata  = 32'h0;
                next_pslverr = 1'b1;
            end
        end
    end

    // Bus answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end
endmodule

// >>> bench/ptd_assertions.sv
// Bus-side checks of the page-table-pointer decoder
module ptd_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ======================================
    // Access phase seen, answer not yet given
    wire acc = psel && penable && !pready;
    wire rd  = acc && !pwrite;
    wire bad = paddr > 12'h020;
    a_ready_wait: assert property (acc |=> pready) else $error("answer late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
    a_ready_cause: assert property (pready |-> $past(acc)) else $error("ready without request");
    a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_unmapped_err: assert property (acc && bad |=> pslverr) else $error("unmapped not refused");
    a_mapped_ok: assert property (acc && !bad && paddr[1:0] == 2'h0 && (!pwrite || paddr <= 12'h010) |=> !pslverr)
        else $error("mapped refused");
    a_unmapped_zero: assert property (rd && bad |=> prdata == 32'h0) else $error("unmapped data");
    a_table_align: assert property (rd && paddr == 12'h014 |=> prdata[11:0] == 12'h000) else $error("align");
    a_table_width: assert property (rd && paddr == 12'h018 |=> prdata[31:16] == 16'h0) else $error("width");
    // Main scenarios
    c_refused: cover property (pready && pslverr);
    c_status: cover property (rd && paddr == 12'h010 ##1 prdata[0]);
    c_table: cover property (rd && paddr == 12'h014);
endmodule
bind ptd_decoder ptd_assertions u_ptd_assertions (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

// >>> bench/ptd_walk_model.sv
// Walk controller model: bus master that hands entries over and reads results
module ptd_walk_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // One transfer: setup, access held until ready, then release
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e, output logic to);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        to = 1'b1;
        for (int n = 0; n < 20 && to; n++) begin
            @(posedge pclk);
            to = (pready !== 1'b1);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // Released data no longer shows the last value
    endtask
endmodule

// >>> bench/pde_table_pointer_decode_tb_top.sv
// Self-checking bench for the page-table-pointer decoder
module pde_table_pointer_decode_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    wire logic   psel, penable, pwrite, pready, pslverr;
    wire logic [11:0] paddr;
    wire logic [31:0] pwdata, prdata;
    int          fails = 0;
    int          checks_done = 0;
    logic [31:0] rv;
    logic        ev, tov;
    // ======================================
    // Clock and instances
    always #12.5 pclk = ~pclk;
    ptd_decoder u_ptd_decoder (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ptd_walk_model u_ptd_walk_model (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // ======================================
    // Shared tasks
    task finish_test;
        $display("Checks %0d, errors %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, g, x);
        end
    endtask
    task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        u_ptd_walk_model.xfer(w, a, d, rv, ev, tov);
        if (tov) begin
            fails++;
            $display("ERROR %0t bus answer timed out", $time);
            finish_test();
        end
    endtask
    // Full decode of one entry with expected status and results
    task walk(input logic [63:0] e, input logic [6:0] c, input logic [2:0] q);
        logic flt;
        logic dn;
        logic [31:0] st;
        flt = !e[0] | e[7] | (|e[51:48]);
        dn = (q[2] & c[0] & e[63]) | (q[0] & !e[2]) | (q[1] & !e[1] & (q[0] | c[2]));
        st = {24'h0, c[6] ? e[4:3] : 2'h0, 1'b0, c[5:3] == 3'h3, dn, flt, !flt, 1'b1};
        acc(1'b1, 12'h000, e[31:0]);
        acc(1'b1, 12'h004, e[63:32]);
        acc(1'b1, 12'h008, {25'h0, c});
        acc(1'b1, 12'h00C, {28'h0, 1'b1, q});
        repeat (3) @(posedge pclk);
        rv = 32'h0; // Last read of another register may have bit 0 set
        for (int n = 0; n < 20 && rv[0] !== 1'b1; n++)
            acc(1'b0, 12'h010, 32'h0);
        if (rv[0] !== 1'b1) begin
            fails++;
            $display("ERROR %0t status poll timed out", $time);
            finish_test();
        end
        chk(rv & 32'h000000DF, st);
        if (!flt) begin
            acc(1'b0, 12'h014, 32'h0);
            chk(rv, e[31:0] & 32'hFFFFF000);
            acc(1'b0, 12'h018, 32'h0);
            chk(rv, {16'h0, e[47:32]});
            acc(1'b0, 12'h01C, 32'h0);
            chk(rv, e[31:0] | 32'h20 | (c[1] ? 32'h400 : 32'h0));
            acc(1'b0, 12'h020, 32'h0);
            chk(rv, e[63:32]);
        end
    endtask
    // ======================================
    // Scenarios
    task s_table;
        walk(64'h0000_1234_5678_901D, 7'h5A, 3'h0);
        walk(64'h0000_00AB_CDEF_F41F, 7'h40, 3'h0);
    endtask
    task s_fault;
        walk(64'h0000_0000_0000_100E, 7'h00, 3'h0);
        walk(64'h0000_0000_0000_1081, 7'h00, 3'h0);
        walk(64'h0001_0000_0000_1001, 7'h00, 3'h0);
        walk(64'h7FF0_0000_0000_0B41, 7'h00, 3'h0);
    endtask
    task s_perm;
        walk(64'h8000_0000_0000_1007, 7'h01, 3'h4);
        walk(64'h8000_0000_0000_1007, 7'h00, 3'h4);
        walk(64'h0000_0000_0000_1003, 7'h00, 3'h1);
        walk(64'h0000_0000_0000_1005, 7'h00, 3'h3);
        walk(64'h0000_0000_0000_1005, 7'h00, 3'h2);
        walk(64'h0000_0000_0000_1005, 7'h04, 3'h2);
    endtask
    task s_bus;
        acc(1'b0, 12'h040, 32'h0);
        chk({31'h0, ev}, 32'h1);
        chk(rv, 32'h0);
        acc(1'b1, 12'h044, 32'hFFFFFFFF);
        chk({31'h0, ev}, 32'h1);
    endtask
    // Reset, then the scenarios in turn
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        s_bus();
        s_table();
        s_fault();
        s_perm();
        finish_test();
    end
endmodule
